// ==== rtl/iewk_pkg.sv ====
// iewk_pkg: shared constants and types for the irq enable / wake block
package iewk_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on apb)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IEWK_ADDR_IE     = 8'h00;
    localparam logic [7:0]  IEWK_ADDR_FLAGS  = 8'h04;
    localparam logic [7:0]  IEWK_ADDR_PWR    = 8'h08;
    localparam logic [7:0]  IEWK_ADDR_STAT   = 8'h0C;

    // interrupt_enable field positions
    localparam int IEWK_BIT_GATE = 7;
    localparam int IEWK_BIT_RSVD = 6;
    localparam int IEWK_NSRC     = 6;
    localparam logic [7:0]  IEWK_IE_RESET    = 8'h00;
    localparam logic [7:0]  IEWK_IE_WMASK    = 8'hBF;

    // flag register positions (write 1 to clear)
    localparam int IEWK_FLG_T0   = 0;
    localparam int IEWK_FLG_T1   = 1;
    localparam int IEWK_FLG_T2W  = 2;
    localparam int IEWK_FLG_T2P  = 3;
    localparam logic [3:0]  IEWK_FLG_RESET   = 4'h0;

    // power control bits
    localparam int IEWK_PWR_IDLE = 0;
    localparam int IEWK_PWR_PD   = 1;

    // source index in the enable register
    localparam int IEWK_SRC_X0   = 0;
    localparam int IEWK_SRC_T0   = 1;
    localparam int IEWK_SRC_X1   = 2;
    localparam int IEWK_SRC_T1   = 3;
    localparam int IEWK_SRC_SP   = 4;
    localparam int IEWK_SRC_T2   = 5;

    // ------------------------------------------------------------------
    // machine cycle timing
    // ------------------------------------------------------------------
    localparam logic [3:0]  IEWK_MC_LAST     = 4'hB;   // 12 phases, 24 osc periods
    localparam logic [3:0]  IEWK_PH_EARLY    = 4'h3;   // state 2 phase 2
    localparam logic [3:0]  IEWK_PH_LATE     = 4'h9;   // state 5 phase 2
    localparam logic [1:0]  IEWK_RST_GUARD   = 2'h2;   // two machine cycles

    // power mode states
    typedef enum logic [2:0] {
        IEWK_RUN  = 3'b001,
        IEWK_IDLE = 3'b010,
        IEWK_PD   = 3'b100
    } iewk_mode_t;

    // interrupt source events from the peripherals
    typedef struct packed {
        logic t0_wrap;
        logic t1_wrap;
        logic t2_wrap;
        logic t2_pin;
        logic uart;
    } iewk_src_t;

    // pin control outputs during low power
    typedef struct packed {
        logic ale;
        logic fetch;
        logic p0_oe;
        logic p2_addr;
    } iewk_pins_t;

endpackage

// ==== rtl/iewk_osc_div.sv ====
// iewk_osc_div: divide-by-two oscillator stage and machine phase counter
`timescale 1ns/10ps
`default_nettype none
module iewk_osc_div
    import iewk_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // oscillator gating
    input  wire logic       osc_run,
    // timing outputs
    output logic            state_en,
    output logic [3:0]      phase_q,
    output logic            mc_end
);

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    logic half_q;

    // toggle stage: output rate ignores the input duty cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            half_q <= 1'b0;
        end else if (osc_run) begin
            half_q <= ~half_q;
        end
    end

    assign state_en = osc_run & half_q;

    // phase counter wraps once per machine cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_q <= 4'h0;
        end else if (state_en) begin
            phase_q <= (phase_q == IEWK_MC_LAST) ? 4'h0 : phase_q + 4'h1;
        end
    end

    assign mc_end = state_en & (phase_q == IEWK_MC_LAST);

endmodule
`default_nettype wire

// ==== rtl/iewk_top.sv ====
// iewk_top: interrupt enable gating, timer flag timing and low power modes
//
// What this block does
// - six vectors: two pins, three timers, serial
// - global gate bit 7 blocks every request
// - per source enable bits 5 down to 0
// - timer 2 request is wrap OR pin
// - timer 2 flags cleared only by software
// - timer 0/1 flags late, polled next cycle
// - timer 2 flag early, polled same cycle
// - clocking through a divide-by-two stage
// - idle halts cpu, peripherals and state kept
// - idle ends on enabled interrupt or reset
// - reset out of idle blocks ram briefly
// - power-down stops oscillator, keeps state
// - power-down ends on reset or pin interrupt
// - reset out of power-down restores registers
// - strobe and port states per low power mode
`timescale 1ns/10ps
`default_nettype none
module iewk_top
    import iewk_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // apb slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic            pready,
    output logic [31:0]     prdata,
    output logic            pslverr,
    // interrupt sources (same clock domain peripherals)
    input  wire iewk_src_t  src,
    // external interrupt pins (asynchronous)
    input  wire logic       irq_pin0,
    input  wire logic       irq_pin1,
    // memory configuration
    input  wire logic       ext_program,
    // cpu side
    output logic [5:0]      irq_req,
    output logic            cpu_run,
    output logic            ram_block,
    output logic            osc_running,
    // pin control
    output iewk_pins_t      pins
);

    // ------------------------------------------------------------------
    // oscillator and machine timing
    // ------------------------------------------------------------------
    iewk_mode_t  mode_q;
    logic        state_en;
    logic [3:0]  phase_q;
    logic        mc_end;
    logic        osc_run;

    assign osc_run = (mode_q != IEWK_PD);

    iewk_osc_div u_div (
        .clock    (clock),
        .rst      (rst),
        .osc_run  (osc_run),
        .state_en (state_en),
        .phase_q  (phase_q),
        .mc_end   (mc_end)
    );

    wire at_late  = state_en & (phase_q == IEWK_PH_LATE);
    wire at_early = state_en & (phase_q == IEWK_PH_EARLY);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] pin_m_q;
    logic [1:0] pin_s_q;

    // two flops before any logic looks at the pins
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_m_q <= 2'h0;
            pin_s_q <= 2'h0;
        end else begin
            pin_m_q <= {irq_pin1, irq_pin0};
            pin_s_q <= pin_m_q;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit_ie   = (paddr == IEWK_ADDR_IE);
    wire hit_flg  = (paddr == IEWK_ADDR_FLAGS);
    wire hit_pwr  = (paddr == IEWK_ADDR_PWR);
    wire hit_stat = (paddr == IEWK_ADDR_STAT);
    wire hit_any  = hit_ie | hit_flg | hit_pwr | hit_stat;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    // ------------------------------------------------------------------
    // interrupt_enable register
    // ------------------------------------------------------------------
    logic [7:0] ie_q;
    logic [7:0] ie_d;

    // bit 6 is not stored, so a stray one from software cannot stick
    assign ie_d = (wr & hit_ie) ? (pwdata[7:0] & IEWK_IE_WMASK) : ie_q;

    // reset restores the register, including a power-down exit
    always_ff @(posedge clock) begin
        if (rst) begin
            ie_q <= IEWK_IE_RESET;
        end else begin
            ie_q <= ie_d;
        end
    end

    // ------------------------------------------------------------------
    // timer flags
    // ------------------------------------------------------------------
    logic [3:0] flg_q;
    logic [3:0] flg_d;
    logic [3:0] flg_set;
    logic [3:0] flg_clr;
    logic [1:0] t01_pend_q;

    // timer 0/1 wrap remembered until the next late phase
    always_ff @(posedge clock) begin
        if (rst) begin
            t01_pend_q <= 2'h0;
        end else begin
            t01_pend_q <= (t01_pend_q | {src.t1_wrap, src.t0_wrap})
                          & ~{2{at_late}};
        end
    end

    // a late set and a software clear in one cycle: the set wins
    assign flg_set[IEWK_FLG_T0]  = at_late & (t01_pend_q[0] | src.t0_wrap);
    assign flg_set[IEWK_FLG_T1]  = at_late & (t01_pend_q[1] | src.t1_wrap);
    assign flg_set[IEWK_FLG_T2W] = src.t2_wrap;
    assign flg_set[IEWK_FLG_T2P] = src.t2_pin;
    assign flg_clr = (wr & hit_flg) ? pwdata[3:0] : 4'h0;
    assign flg_d   = flg_set | (flg_q & ~flg_clr);

    always_ff @(posedge clock) begin
        if (rst) begin
            flg_q <= IEWK_FLG_RESET;
        end else begin
            flg_q <= flg_d;
        end
    end

    // ------------------------------------------------------------------
    // polling samples
    // ------------------------------------------------------------------
    logic [1:0] t01_poll_q;
    logic       t2_poll_q;

    // timer 0/1 seen at next machine cycle; timer 2 within the same one
    always_ff @(posedge clock) begin
        if (rst) begin
            t01_poll_q <= 2'h0;
            t2_poll_q  <= 1'b0;
        end else begin
            if (mc_end) begin
                t01_poll_q <= {flg_q[IEWK_FLG_T1], flg_q[IEWK_FLG_T0]};
            end
            if (at_early | mc_end) begin
                t2_poll_q <= flg_q[IEWK_FLG_T2W]
                             | flg_q[IEWK_FLG_T2P];
            end
        end
    end

    // ------------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------------
    logic [5:0] raw;

    assign raw[IEWK_SRC_X0] = ~pin_s_q[0];
    assign raw[IEWK_SRC_T0] = t01_poll_q[0];
    assign raw[IEWK_SRC_X1] = ~pin_s_q[1];
    assign raw[IEWK_SRC_T1] = t01_poll_q[1];
    assign raw[IEWK_SRC_SP] = src.uart;
    assign raw[IEWK_SRC_T2] = t2_poll_q;

    logic [5:0] gated;

    // each source passes only with its enable and the global gate
    genvar gi;
    generate
        for (gi = 0; gi < IEWK_NSRC; gi++) begin : g_src
            assign gated[gi] = raw[gi] & ie_q[gi]
                               & ie_q[IEWK_BIT_GATE];
        end
    endgenerate

    logic [5:0] irq_q;

    // registered request lines to the cpu
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 6'h00;
        end else begin
            irq_q <= gated;
        end
    end
    assign irq_req = irq_q;

    // ------------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------------
    wire req_idle  = wr & hit_pwr & pwdata[IEWK_PWR_IDLE];
    wire req_pd    = wr & hit_pwr & pwdata[IEWK_PWR_PD];
    wire any_wake  = |gated;
    wire pin_wake  = gated[IEWK_SRC_X0] | gated[IEWK_SRC_X1];

    iewk_mode_t mode_d;

    // power-down takes precedence when both bits are written
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            IEWK_RUN: begin
                if (req_pd) begin
                    mode_d = IEWK_PD;
                end else if (req_idle) begin
                    mode_d = IEWK_IDLE;
                end
            end
            IEWK_IDLE: begin
                if (any_wake) begin
                    mode_d = IEWK_RUN;
                end
            end
            IEWK_PD: begin
                if (pin_wake) begin
                    mode_d = IEWK_RUN;
                end
            end
            default: begin
                mode_d = IEWK_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= IEWK_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // reset out of idle: brief ram guard
    // ------------------------------------------------------------------
    logic       was_idle_q;
    logic [1:0] guard_q;

    // remembers idle across reset so the guard can start after release
    always_ff @(posedge clock) begin
        if (rst) begin
            guard_q <= 2'h0;
        end else if (was_idle_q) begin
            guard_q <= IEWK_RST_GUARD;
        end else if (mc_end && guard_q != 2'h0) begin
            guard_q <= guard_q - 2'h1;
        end
    end

    // set by a reset edge that finds idle and held for the rest of that
    // reset, since mode is already back to run after the first reset edge
    always_ff @(posedge clock) begin
        if (rst) begin
            if (mode_q == IEWK_IDLE) begin
                was_idle_q <= 1'b1;
            end
        end else begin
            was_idle_q <= 1'b0;
        end
    end

    assign ram_block = (guard_q != 2'h0);

    // ------------------------------------------------------------------
    // status read back
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;

    assign rd_mux = hit_ie   ? {24'h000000, ie_q} :
                    hit_flg  ? {28'h0000000, flg_q} :
                    hit_pwr  ? {29'h0, mode_q} :
                    hit_stat ? {26'h0, irq_q} : 32'h00000000;

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // cpu and pin controls
    // ------------------------------------------------------------------
    assign cpu_run     = (mode_q == IEWK_RUN);
    assign osc_running = osc_run;

    logic [3:0] pins_q;

    // idle drives strobes high, power-down low; port 0 floats externally
    always_ff @(posedge clock) begin
        if (rst) begin
            pins_q <= 4'h3;
        end else begin
            pins_q[3] <= (mode_q != IEWK_PD);
            pins_q[2] <= (mode_q != IEWK_PD);
            pins_q[1] <= ~(ext_program & (mode_q != IEWK_RUN));
            pins_q[0] <= ext_program & (mode_q != IEWK_PD);
        end
    end
    assign pins = pins_q;

endmodule
`default_nettype wire

// ==== verification/iewk_chk.sv ====
// iewk_chk: port-level assertions for the irq enable / wake block
`timescale 1ns/10ps
`default_nettype none
module iewk_chk
    import iewk_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // cpu and pin side
    input  wire logic        ext_program,
    input  wire logic [5:0]  irq_req,
    input  wire logic        cpu_run,
    input  wire logic        ram_block,
    input  wire logic        osc_running,
    input  wire iewk_pins_t  pins
);
    logic [7:0] ie_s_q;
    logic [7:0] ie_s_d;
    logic [6:0] blk_q;
    logic [6:0] blk_d;
    logic       gate_s;
    logic       idle;
    logic       mapped;
    // shadow of the enable register, seen only through apb writes
    assign ie_s_d = (psel & penable & pwrite & (paddr == IEWK_ADDR_IE)) ?
                    (pwdata[7:0] & IEWK_IE_WMASK) : ie_s_q;
    assign gate_s = ie_s_q[IEWK_BIT_GATE];
    assign blk_d  = ram_block ? blk_q + 7'h01 : 7'h00;
    assign idle   = !cpu_run & osc_running;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= IEWK_ADDR_STAT);
    // counter replaces a long repetition the tools would unroll
    always_ff @(posedge clock) begin
        ie_s_q <= rst ? IEWK_IE_RESET : ie_s_d;
        blk_q  <= rst ? 7'h00 : blk_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_gate_off: assert property (
        !gate_s && !$past(gate_s) |-> irq_req == 6'h00)
        else $error("request while gate off");
    a_enable_mask: assert property (
        ({2'h0, irq_req} & ~(ie_s_q | $past(ie_s_q)) & 8'h3F) == 8'h00)
        else $error("request from a disabled source");
    a_idle_pins: assert property (
        idle && $past(idle) && $stable(ext_program) |-> pins.ale &&
        pins.fetch && pins.p0_oe == !ext_program &&
        pins.p2_addr == ext_program)
        else $error("pin states wrong in idle");
    a_pd_pins: assert property (
        !osc_running && !$past(osc_running) && $stable(ext_program) |->
        !pins.ale && !pins.fetch && pins.p0_oe == !ext_program &&
        !pins.p2_addr)
        else $error("pin states wrong in power-down");
    a_pd_cpu_stop: assert property (!osc_running |-> !cpu_run)
        else $error("cpu running with oscillator stopped");
    a_idle_wake: assert property (
        $past(idle) && irq_req != 6'h00 |-> cpu_run)
        else $error("idle not left on request");
    a_pd_wake_pin: assert property (
        $rose(osc_running) |-> ##[0:3] (irq_req[0] || irq_req[2]))
        else $error("power-down left without pin request");
    a_ram_guard: assert property (
        $fell(ram_block) |-> blk_q inside {[20:50]})
        else $error("ram guard length wrong");
endmodule
bind iewk_top iewk_chk u_chk (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ext_program(ext_program), .irq_req(irq_req),
    .cpu_run(cpu_run), .ram_block(ram_block), .osc_running(osc_running),
    .pins(pins)
);
`default_nettype wire

// ==== verification/iewk_periph.sv ====
// iewk_periph: timer, serial and pin stand-in facing the irq block
`timescale 1ns/10ps
`default_nettype none
module iewk_periph
    import iewk_pkg::*;
(
    // bench commands
    input  wire logic [3:0] fire,
    input  wire logic       uart_on,
    input  wire logic [1:0] pin_on,
    // toward the block
    output iewk_src_t       src,
    output logic            irq_pin0,
    output logic            irq_pin1
);
    // events pass through as the bench's one-cycle pulses
    assign src.t0_wrap = fire[0];
    assign src.t1_wrap = fire[1];
    assign src.t2_wrap = fire[2];
    assign src.t2_pin  = fire[3];
    assign src.uart    = uart_on;
    // pins rest high; a held low level keeps asking until released
    assign irq_pin0 = !pin_on[0];
    assign irq_pin1 = !pin_on[1];
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// tb: self-checking bench for the irq enable / wake block
`timescale 1ns/10ps
`default_nettype none
module tb
    import iewk_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        ext_program = 1'b0;
    logic [3:0]  fire = 4'h0;
    logic        uart_on = 1'b0;
    logic [1:0]  pin_on = 2'h0;
    logic        pready, pslverr, irq_pin0, irq_pin1, cpu_run;
    logic        ram_block, osc_running, e;
    logic [31:0] prdata, r;
    logic [31:0] seed = 32'h5;
    logic [5:0]  irq_req;
    iewk_src_t   src;
    iewk_pins_t  pins;
    int          err_count = 0;
    int          comparisons = 0;
    int          m_ie, m_flg, n, k;
    initial begin
        forever #5 clock = ~clock;
    end
    iewk_top dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src(src),
        .irq_pin0(irq_pin0), .irq_pin1(irq_pin1), .ext_program(ext_program),
        .irq_req(irq_req), .cpu_run(cpu_run), .ram_block(ram_block),
        .osc_running(osc_running), .pins(pins)
    );
    iewk_periph u_per (
        .fire(fire), .uart_on(uart_on), .pin_on(pin_on), .src(src),
        .irq_pin0(irq_pin0), .irq_pin1(irq_pin1)
    );
    // ------------------------------------------------------------------
    // model and helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected requests: pending sources masked by enables and gate
    function automatic logic [5:0] exp_irq();
        logic [5:0] p;
        p = {m_flg[3] | m_flg[2], uart_on, m_flg[1], pin_on[1], m_flg[0],
             pin_on[0]};
        return m_ie[7] ? (p & m_ie[5:0]) : 6'h00;
    endfunction
    function automatic logic [5:0] probe(input int sel);
        return sel == 0 ? irq_req : sel == 1 ? {5'h0, cpu_run} :
               {5'h0, ram_block};
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd_q,
                       output logic er);
        int c;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (pready !== 1'b1 && c < 50);
        if (c >= 50) begin
            err_count++;
            give_verdict();
        end
        rd_q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                      input string nm);
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, ex, r);
    endtask
    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask
    task automatic pulse(input int i);
        fire <= 4'h1 << i;
        @(posedge clock);
        fire <= 4'h0;
        m_flg = m_flg | (1 << i);
    endtask
    // bounded wait; running out ends the run as a failure
    task automatic wait_for(input int sel, input logic [5:0] ex,
                            input string nm, output int cnt);
        cnt = 0;
        while (probe(sel) !== ex && cnt < 200) begin
            @(posedge clock);
            cnt++;
        end
        if (cnt >= 200) begin
            err_count++;
            give_verdict();
        end else begin
            chk(nm, {26'h0, ex}, {26'h0, probe(sel)});
        end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        m_ie = 0;
        m_flg = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(IEWK_ADDR_IE, IEWK_IE_RESET, "ie reset");
        rd(IEWK_ADDR_PWR, 32'h1, "mode reset");
        rd(IEWK_ADDR_FLAGS, 32'h0, "flags reset");
        wt(IEWK_ADDR_IE, 32'hFF);
        rd(IEWK_ADDR_IE, 32'hBF, "ie reserved");
        for (k = 0; k < 4; k++) begin
            m_ie = xs() & 32'hBF;
            wt(IEWK_ADDR_IE, m_ie);
            rd(IEWK_ADDR_IE, m_ie, "ie rw");
        end
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk("slverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            m_ie = 32'h80 | (32'h1 << (2 * (k > 1 ? 2 : k) + 1));
            wt(IEWK_ADDR_IE, m_ie);
            pulse(k);
            wait_for(0, exp_irq(), "irq source", n);
            rd(IEWK_ADDR_STAT, exp_irq(), "status");
            if (k > 1) chk("t2 latency", 32'h1, {31'h0, n < 30});
            rd(IEWK_ADDR_FLAGS, m_flg, "flag held");
            wt(IEWK_ADDR_FLAGS, m_flg);
            m_flg = 0;
            wait_for(0, 6'h00, "irq cleared", n);
        end
        m_ie = 32'h3F;
        wt(IEWK_ADDR_IE, m_ie);
        pulse(0);
        repeat (60) @(posedge clock);
        chk("irq gated", 32'h0, {26'h0, irq_req});
        m_ie = 32'hBF;
        wt(IEWK_ADDR_IE, m_ie);
        wait_for(0, exp_irq(), "irq ungated", n);
        wt(IEWK_ADDR_FLAGS, 32'h1);
        m_flg = 0;
        $display("test sources done");
        for (k = 0; k < 6; k++) begin
            r = xs();
            pin_on <= r[1:0];
            uart_on <= r[2];
            @(posedge clock);
            wait_for(0, exp_irq(), "irq level", n);
        end
        pin_on <= 2'h0;
        uart_on <= 1'b0;
        ext_program <= 1'b1;
        wt(IEWK_ADDR_PWR, 32'h1);
        rd(IEWK_ADDR_PWR, 32'h2, "mode idle");
        pulse(0);
        wait_for(1, 6'h1, "idle wake", n);
        rd(IEWK_ADDR_FLAGS, 32'h1, "flag in idle");
        wt(IEWK_ADDR_FLAGS, 32'h1);
        m_flg = 0;
        ext_program <= 1'b0;
        wt(IEWK_ADDR_PWR, 32'h2);
        rd(IEWK_ADDR_PWR, 32'h4, "mode pd");
        uart_on <= 1'b1;
        repeat (60) @(posedge clock);
        chk("no serial wake", 32'h0, {31'h0, cpu_run});
        chk("osc stopped", 32'h0, {31'h0, osc_running});
        pin_on <= 2'h1;
        wait_for(1, 6'h1, "pin wake", n);
        rd(IEWK_ADDR_IE, 32'hBF, "ie kept");
        pin_on <= 2'h0;
        uart_on <= 1'b0;
        $display("test low power done");
        for (k = 1; k < 3; k++) begin
            // timer 0 poll may still be stale here, so keep it disabled
            wt(IEWK_ADDR_IE, 32'hB5);
            wt(IEWK_ADDR_PWR, k);
            rst <= 1'b1;
            repeat (10) @(posedge clock);
            rst <= 1'b0;
            repeat (2) @(posedge clock);
            if (k == 1) begin
                chk("ram guard on", 32'h1, {31'h0, ram_block});
                wait_for(2, 6'h0, "ram guard off", n);
                chk("guard span", 32'h1, {31'h0, n inside {[38:48]}});
            end
            rd(IEWK_ADDR_IE, 32'h0, "ie after reset");
            rd(IEWK_ADDR_PWR, 32'h1, "mode after reset");
        end
        $display("test reset exit done");
        give_verdict();
    end
endmodule
`default_nettype wire
